// ===== ibc_regs.sv
/*
 * Identity bytes and the block-read length register, with the byte
 * sequencer that feeds a block read.
 * Assumes a serial management front end on the same clock that decodes
 * the two-wire protocol and hands over byte-wide requests.
 */
// Overview of operation
// - reading byte 4 returns all ones
// - byte 5 is read-only: revision in upper nibble, maker code lower
// - byte 6 is read-only: class in bits 7:6, identity in bits 5:0
// - host writes byte 7 bits 4:0; that count sets block read length
// - after reset the read length is eight
// - block read sends the count first, then bytes ascending from start index
module ibc_regs (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire ibc_pkg::ibc_wr_t WRITE_REQ,
	input wire logic RD_STB,
	input wire logic [7:0] RD_INDEX,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	input wire logic BLK_START,
	input wire logic [7:0] BLK_INDEX,
	input wire logic BLK_NEXT,
	input wire logic BLK_STOP,
	output ibc_pkg::ibc_blk_t BLK
);
	logic [4:0] read_length;
	logic [4:0] next_read_length;
	logic [7:0] rd_mux;
	logic [7:0] blk_mux;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	ibc_pkg::ibc_blk_state_t state;
	ibc_pkg::ibc_blk_state_t next_state;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [4:0] left;
	logic [4:0] next_left;
	ibc_pkg::ibc_blk_t next_blk;

	ibc_byte_mux u_rd_mux (
		.index(RD_INDEX),
		.read_length(read_length),
		.data(rd_mux)
	);

	ibc_byte_mux u_blk_mux (
		.index(ptr),
		.read_length(read_length),
		.data(blk_mux)
	);

	// read-length register
	always_comb begin
		next_read_length = read_length;
		if (WRITE_REQ.stb && WRITE_REQ.index == ibc_pkg::IDX_LEN) begin
			// upper bits dropped here
			next_read_length = WRITE_REQ.data[ibc_pkg::LEN_HI:ibc_pkg::LEN_LO];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			read_length <= ibc_pkg::LEN_RESET;
		end else begin
			read_length <= next_read_length;
		end
	end

	// single-byte read port
	always_comb begin
		next_rd_valid = RD_STB;
		next_rd_data = RD_DATA;
		if (RD_STB) begin
			next_rd_data = rd_mux;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			RD_DATA <= 8'h00;
			RD_VALID <= 1'b0;
		end else begin
			RD_DATA <= next_rd_data;
			RD_VALID <= next_rd_valid;
		end
	end

	// block read sequencer; count latched at start so a write mid-read
	// does not change the length of the read in flight
	always_comb begin
		next_state = state;
		next_ptr = ptr;
		next_left = left;
		next_blk = BLK;
		case (state)
		ibc_pkg::BLK_IDLE: begin
			if (BLK_START) begin
				next_ptr = BLK_INDEX;
				next_left = read_length;
				next_blk.valid = 1'b1;
				next_blk.last = (read_length == 5'h00);
				next_blk.data = {ibc_pkg::LEN_PAD, read_length};
				next_state = ibc_pkg::BLK_COUNT;
			end
		end
		ibc_pkg::BLK_COUNT, ibc_pkg::BLK_DATA: begin
			if (BLK_STOP || (BLK_NEXT && left == 5'h00)) begin
				next_blk = '0;
				next_state = ibc_pkg::BLK_IDLE;
			end else if (BLK_NEXT) begin
				next_blk.valid = 1'b1;
				next_blk.last = (left == 5'h01);
				next_blk.data = blk_mux;
				next_ptr = ptr + 8'h01;
				next_left = left - 5'h01;
				next_state = ibc_pkg::BLK_DATA;
			end
		end
		default: begin
			next_blk = '0;
			next_state = ibc_pkg::BLK_IDLE;
		end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			state <= ibc_pkg::BLK_IDLE;
			ptr <= 8'h00;
			left <= 5'h00;
			BLK <= '0;
		end else begin
			state <= next_state;
			ptr <= next_ptr;
			left <= next_left;
			BLK <= next_blk;
		end
	end

	a_rsvd_reads_ones: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		RD_STB && RD_INDEX == ibc_pkg::IDX_RSVD |=> RD_VALID && RD_DATA == 8'hff)
		else $error("reserved byte did not read all ones");

	a_rev_byte_const: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		RD_STB && RD_INDEX == ibc_pkg::IDX_REV
		|=> RD_DATA == {ibc_pkg::SILICON_REV, ibc_pkg::MAKER_CODE})
		else $error("revision byte wrong");

	a_class_byte_const: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		RD_STB && RD_INDEX == ibc_pkg::IDX_CLASS
		|=> RD_DATA[7:6] == ibc_pkg::PART_CLASS
		&& RD_DATA[5:0] == ibc_pkg::PART_IDENTITY)
		else $error("class byte wrong");

	a_count_write_read: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		WRITE_REQ.stb && WRITE_REQ.index == ibc_pkg::IDX_LEN && !RD_STB
		##1 RD_STB && RD_INDEX == ibc_pkg::IDX_LEN && !WRITE_REQ.stb
		|=> RD_DATA[4:0] == $past(WRITE_REQ.data[4:0], 2))
		else $error("written read length not read back");

	a_count_after_reset: assert property (
		@(posedge CLOCK)
		!RST_B |=> read_length == 5'h08)
		else $error("read length not eight after reset");

	a_blk_count_first: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state == ibc_pkg::BLK_IDLE && BLK_START
		|=> BLK.valid && BLK.data == {3'h0, $past(read_length)}
		&& state == ibc_pkg::BLK_COUNT)
		else $error("block read did not open with the count");

	a_blk_ascending: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state != ibc_pkg::BLK_IDLE && BLK_NEXT && !BLK_STOP && left != 5'h00
		|=> ptr == $past(ptr) + 8'h01 && left == $past(left) - 5'h01
		&& state == ibc_pkg::BLK_DATA)
		else $error("block read did not advance one byte");

	a_rsvd_bits_zero: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		RD_STB && RD_INDEX == ibc_pkg::IDX_LEN |=> RD_DATA[7:5] == 3'h0)
		else $error("reserved length bits not zero");

	a_len_holds: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		!(WRITE_REQ.stb && WRITE_REQ.index == ibc_pkg::IDX_LEN)
		|=> read_length == $past(read_length))
		else $error("read length changed without a write");

	a_blk_zero_last: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state == ibc_pkg::BLK_IDLE && BLK_START && read_length == 5'h00
		|=> BLK.valid && BLK.last)
		else $error("empty block read count not marked last");

	a_blk_last_marks: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state != ibc_pkg::BLK_IDLE && BLK_NEXT && !BLK_STOP
		&& left == 5'h01 |=> BLK.valid && BLK.last)
		else $error("final block read byte not marked last");

	a_blk_ends_after_last: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state != ibc_pkg::BLK_IDLE && BLK.last && BLK_NEXT
		|=> !BLK.valid && state == ibc_pkg::BLK_IDLE)
		else $error("block read ran past its count");

	a_blk_stop_clears: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state != ibc_pkg::BLK_IDLE && BLK_STOP
		|=> !BLK.valid && !BLK.last && BLK.data == 8'h00
		&& state == ibc_pkg::BLK_IDLE)
		else $error("block read did not end on stop");

	a_blk_rsvd_byte: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		state != ibc_pkg::BLK_IDLE && BLK_NEXT && !BLK_STOP
		&& left != 5'h00 && ptr == ibc_pkg::IDX_RSVD
		|=> BLK.data == ibc_pkg::RSVD_VALUE)
		else $error("reserved byte wrong in block read");
endmodule

// ===== ibc_pkg.sv
/*
 * Shared constants and carrier types for the identity and read-length
 * register bank.
 * Assumes a single 50 MHz clock shared with the serial management front end.
 */
package ibc_pkg;
	// register indexes
	localparam logic [7:0] IDX_RSVD = 8'h04;
	localparam logic [7:0] IDX_REV = 8'h05;
	localparam logic [7:0] IDX_CLASS = 8'h06;
	localparam logic [7:0] IDX_LEN = 8'h07;
	// values
	localparam logic [7:0] RSVD_VALUE = 8'hff;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
	localparam logic [4:0] LEN_RESET = 5'h08;
	localparam logic [2:0] LEN_PAD = 3'h0;
	// field positions of the read-length register
	localparam int LEN_HI = 4;
	localparam int LEN_LO = 0;
	// identity fields: values are arbitrary
	localparam logic [3:0] SILICON_REV = 4'h3;
	localparam logic [3:0] MAKER_CODE = 4'h5;
	localparam logic [1:0] PART_CLASS = 2'h2;
	localparam logic [5:0] PART_IDENTITY = 6'h2a;

	typedef struct packed {
		logic stb;
		logic [7:0] index;
		logic [7:0] data;
	} ibc_wr_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} ibc_blk_t;

	typedef enum logic [1:0] {
		BLK_IDLE,
		BLK_COUNT,
		BLK_DATA
	} ibc_blk_state_t;
endpackage

// ===== ibc_byte_mux.sv
/*
 * Read decode of one register byte from its index.
 * Assumes the read-length value is supplied by the register bank.
 */
module ibc_byte_mux (
	input wire logic [7:0] index,
	input wire logic [4:0] read_length,
	output logic [7:0] data
);
	always_comb begin
		if (index == ibc_pkg::IDX_RSVD) begin
			data = ibc_pkg::RSVD_VALUE;
		end else if (index == ibc_pkg::IDX_REV) begin
			data = {ibc_pkg::SILICON_REV, ibc_pkg::MAKER_CODE};
		end else if (index == ibc_pkg::IDX_CLASS) begin
			data = {ibc_pkg::PART_CLASS, ibc_pkg::PART_IDENTITY};
		end else if (index == ibc_pkg::IDX_LEN) begin
			data = {ibc_pkg::LEN_PAD, read_length};
		end else begin
			data = ibc_pkg::UNMAPPED_VALUE;
		end
	end
endmodule

// ===== ibc_host.sv
/* host model that runs block reads and keeps the bytes it took
   assumes ibc_regs on the same clock */
module ibc_host (
	input wire logic CLOCK,
	input wire ibc_pkg::ibc_blk_t BLK,
	output logic START,
	output logic [7:0] INDEX,
	output logic NEXT,
	output logic STOP
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [0:63];
	logic lst [0:63];
	int n;
	initial {START, INDEX, NEXT, STOP} = '0;
	// slow host: one idle cycle around each acknowledge
	task automatic block_read(input logic [7:0] idx, input int cut);
		n = 0;
		@(posedge CLOCK);
		START <= 1'b1;
		INDEX <= idx;
		@(posedge CLOCK);
		START <= 1'b0;
		@(posedge CLOCK);
		#1;
		while (BLK.valid === 1'b1 && n < 60) begin
			got[n] = BLK.data;
			lst[n] = BLK.last;
			n++;
			@(posedge CLOCK);
			if (n == cut)
				STOP <= 1'b1;
			else
				NEXT <= 1'b1;
			@(posedge CLOCK);
			{NEXT, STOP} <= 2'b00;
			@(posedge CLOCK);
			#1;
		end
	endtask
endmodule

// ===== ibc_regs_tb.sv
/* self-checking bench for ibc_regs
   assumes ibc_host as the block-read partner */
module ibc_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	ibc_pkg::ibc_wr_t wr = '0;
	logic rd_stb = 1'b0;
	logic [7:0] rd_index = 8'h00;
	logic [7:0] rd_data;
	logic rd_valid;
	logic start;
	logic next;
	logic stop;
	logic [7:0] index;
	ibc_pkg::ibc_blk_t blk;
	int err_count = 0;
	int checked = 0;
	always #10 clock = ~clock;
	ibc_regs dut (.CLOCK(clock), .RST_B(rst_b), .WRITE_REQ(wr),
		.RD_STB(rd_stb), .RD_INDEX(rd_index), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .BLK_START(start), .BLK_INDEX(index),
		.BLK_NEXT(next), .BLK_STOP(stop), .BLK(blk));
	ibc_host host (.CLOCK(clock), .BLK(blk), .START(start),
		.INDEX(index), .NEXT(next), .STOP(stop));
	function automatic logic [7:0] reg_byte(logic [7:0] i, logic [4:0] len);
		case (i)
			8'h04: return 8'hff;
			8'h05: return {ibc_pkg::SILICON_REV, ibc_pkg::MAKER_CODE};
			8'h06: return {ibc_pkg::PART_CLASS, ibc_pkg::PART_IDENTITY};
			8'h07: return {3'h0, len};
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_byte(logic [7:0] i, logic [7:0] d);
		@(posedge clock);
		wr <= '{1'b1, i, d};
		@(posedge clock);
		wr <= '0;
	endtask
	task automatic rd_chk(logic [7:0] i, logic [7:0] exp);
		@(posedge clock);
		rd_stb <= 1'b1;
		rd_index <= i;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		chk("rd_valid", 8'h01, {7'h00, rd_valid});
		chk("rd_data", exp, rd_data);
	endtask
	task automatic blk_chk(logic [7:0] i, logic [4:0] len, int cut);
		int n;
		n = (cut < len + 1) ? cut : len + 1;
		host.block_read(i, cut);
		chk("blk_bytes", 8'(n), 8'(host.n));
		chk("blk_count", {3'h0, len}, host.got[0]);
		for (int k = 1; k < n; k++)
			chk("blk_byte", reg_byte(i + 8'(k - 1), len), host.got[k]);
		for (int k = 0; k < n; k++)
			chk("blk_last", 8'(k == len), {7'h00, host.lst[k]});
	endtask
	// write then read back on the very next cycle
	task automatic wr_rd_chk(logic [7:0] d, logic [7:0] exp);
		@(posedge clock);
		wr <= '{1'b1, ibc_pkg::IDX_LEN, d};
		@(posedge clock);
		wr <= '0;
		rd_stb <= 1'b1;
		rd_index <= ibc_pkg::IDX_LEN;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		chk("rd_back_valid", 8'h01, {7'h00, rd_valid});
		chk("rd_back", exp, rd_data);
	endtask
	task automatic give_verdict();
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 3; i < 8; i++)
			rd_chk(8'(i), reg_byte(8'(i), 5'h08));
		blk_chk(8'h04, 5'h08, 99);
		for (int i = 4; i < 7; i++)
			wr_byte(8'(i), 8'h00);
		wr_byte(8'h07, 8'hff);
		for (int i = 4; i < 8; i++)
			rd_chk(8'(i), reg_byte(8'(i), 5'h1f));
		wr_byte(8'h07, 8'he2);
		rd_chk(8'h07, 8'h02);
		blk_chk(8'h05, 5'h02, 99);
		wr_byte(8'h07, 8'h00);
		blk_chk(8'hfe, 5'h00, 99);
		wr_byte(8'h07, 8'h1f);
		blk_chk(8'hf0, 5'h1f, 99);
		blk_chk(8'h04, 5'h1f, 3);
		wr_rd_chk(8'hb3, 8'h13);
		// mid-run reset must restore the default length
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		chk("rd_data_reset", 8'h00, rd_data);
		chk("rd_valid_reset", 8'h00, {7'h00, rd_valid});
		rd_chk(8'h07, reg_byte(8'h07, 5'h08));
		blk_chk(8'h06, 5'h08, 99);
		give_verdict();
	end
	// about 240 cycles expected
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
endmodule
